// ===== rtl/rfs_pkg.sv
// Constants for the second-area record framing controller.
// Assumes one data clock shared with the enclosing acquisition design.
package rfs_pkg;

   // Reduced rate bus channel layout
   localparam int SAMPLE_BITS   = 16;
   localparam int PAR_SAMPLES   = 8;
   localparam int DATA_BITS     = SAMPLE_BITS * PAR_SAMPLES;
   localparam int GP_BITS       = 16;
   localparam int RCNT_BITS     = 16;
   localparam int UID_BITS      = 8;
   localparam int TNUM_BITS     = 8;
   localparam int XPREC_BITS    = 16;
   localparam int REC_BITS      = 2;
   localparam int REC_START_BIT = 0;
   localparam int REC_STOP_BIT  = 1;

   // AXI4-Lite
   localparam int AXI_ADDR_BITS = 8;
   localparam int AXI_DATA_BITS = 32;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_UID       = 8'h04;
   localparam logic [7:0] OFS_DROP_MASK = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;
   localparam logic [7:0] OFS_START_CNT = 8'h10;
   localparam logic [7:0] OFS_STOP_CNT  = 8'h14;
   localparam logic [7:0] OFS_DROP_CNT  = 8'h18;
   localparam logic [7:0] OFS_LAST_GP   = 8'h1C;
   localparam logic [7:0] OFS_LAST_RCNT = 8'h20;

   // Control register fields
   localparam int CTRL_STREAM_BIT = 0;
   localparam int CTRL_DROP_BIT   = 1;
   localparam int CTRL_UIDOVR_BIT = 2;
   localparam int CTRL_BITS       = 3;

   // Status register fields
   localparam int STAT_OPEN_BIT  = 0;
   localparam int STAT_FERR_BIT  = 1;
   localparam int STAT_DROP_BIT  = 2;

   // Reset values
   localparam logic [CTRL_BITS-1:0] CTRL_RESET = 3'h0;
   localparam logic [UID_BITS-1:0]  UID_RESET  = 8'h00;
   localparam logic [RCNT_BITS-1:0] MASK_RESET = 16'h0000;

   localparam int EVT_CNT_BITS = 32;

endpackage

// ===== rtl/rfs_evt_cnt.sv
// Event counter with synchronous clear, wraps at full width.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/100ps
module rfs_evt_cnt #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,    // Data clock
   input  wire logic             rst_n,  // Synchronous reset, active low
   input  wire logic             inc,    // Count one event
   input  wire logic             clr,    // Clear to zero
   output logic      [WIDTH-1:0] count   // Current count
);

   logic [WIDTH-1:0] cnt_ff;

   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         cnt_ff <= '0;
      end else if (inc) begin
         cnt_ff <= cnt_ff + WIDTH'(1);
      end
   end

   assign count = cnt_ff;

endmodule

// ===== rtl/rfs_ul2_ctrl.sv
// Second-area custom logic for one reduced rate bus channel: forwards
// data and sideband, may drop whole records, reports over AXI4-Lite.
// Assumes the bus comes from the enclosing design on CLK.
//
// Summary of operation
// - General purpose vector is sixteen bits, free for custom use.
// - Tolerate general purpose skew; capture it only at valid record start.
// - Framing field is two bits: start at bit 0, stop at bit 1.
// - Words in valid start or stop cycles belong to the record.
// - Data valid may be low while either framing bit is high.
// - Exactly one stop per start; drop records only as start-stop pairs.
// - Framing bits count only in cycles with data valid.
// - Single-word record has start and stop in one valid cycle.
// - Framing bits may linger; only the valid cycle marks the event.
// - Multi-record mode keeps records intact; streaming may drop records.
// - Use trigger members individually, never the packed bundle.
// - Data valid marks every sample of the word as valid.
// - Real-time bus has no data valid; every cycle is valid.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module rfs_ul2_ctrl (
   input  wire logic                          CLK,          // Data clock
   input  wire logic                          RESET_N,      // Sync reset
   // Reduced rate bus in
   input  wire logic [rfs_pkg::DATA_BITS-1:0] IN_DATA,      // Data word
   input  wire logic                          IN_VALID,     // Data valid
   input  wire logic [rfs_pkg::REC_BITS-1:0]  IN_REC,       // Framing
   input  wire logic                          IN_OVR,       // Overrange
   input  wire logic [rfs_pkg::GP_BITS-1:0]   IN_GP,        // General purp.
   input  wire logic [rfs_pkg::RCNT_BITS-1:0] IN_RCNT,      // Record count
   input  wire logic [rfs_pkg::UID_BITS-1:0]  IN_UID,       // User id
   input  wire logic                          IN_TEVT,      // Trigger event
   input  wire logic                          IN_TRISE,     // Trigger edge
   input  wire logic [rfs_pkg::TNUM_BITS-1:0] IN_TNUM,      // Trigger number
   input  wire logic                          IN_REVT,      // Reset event
   input  wire logic                          IN_REVT_PT,   // Reset ev, pret.
   input  wire logic                          IN_RRISE,     // Reset edge
   input  wire logic [rfs_pkg::TNUM_BITS-1:0] IN_RNUM,      // Reset number
   input  wire logic [rfs_pkg::XPREC_BITS-1:0] IN_XPREC,    // Ext. precision
   // Reduced rate bus out
   output logic      [rfs_pkg::DATA_BITS-1:0] OUT_DATA,     // Data word
   output logic                               OUT_VALID,    // Data valid
   output logic      [rfs_pkg::REC_BITS-1:0]  OUT_REC,      // Framing bits
   output logic                               OUT_OVR,      // Overrange
   output logic      [rfs_pkg::GP_BITS-1:0]   OUT_GP,       // General purp.
   output logic      [rfs_pkg::RCNT_BITS-1:0] OUT_RCNT,     // Record count
   output logic      [rfs_pkg::UID_BITS-1:0]  OUT_UID,      // User id
   output logic                               OUT_TEVT,     // Trigger event
   output logic                               OUT_TRISE,    // Trigger edge
   output logic      [rfs_pkg::TNUM_BITS-1:0] OUT_TNUM,     // Trigger number
   output logic                               OUT_REVT,     // Reset event
   output logic                               OUT_REVT_PT,  // Reset ev, pret.
   output logic                               OUT_RRISE,    // Reset edge
   output logic      [rfs_pkg::TNUM_BITS-1:0] OUT_RNUM,     // Reset number
   output logic      [rfs_pkg::XPREC_BITS-1:0] OUT_XPREC,   // Ext. precision
   // AXI4-Lite slave
   input  wire logic [7:0]                    S_AXI_AWADDR,  // Write addr
   input  wire logic                          S_AXI_AWVALID, // Addr valid
   output logic                               S_AXI_AWREADY, // Addr ready
   input  wire logic [31:0]                   S_AXI_WDATA,   // Write data
   input  wire logic [3:0]                    S_AXI_WSTRB,   // Byte strobes
   input  wire logic                          S_AXI_WVALID,  // Data valid
   output logic                               S_AXI_WREADY,  // Data ready
   output logic      [1:0]                    S_AXI_BRESP,   // Write resp
   output logic                               S_AXI_BVALID,  // Resp valid
   input  wire logic                          S_AXI_BREADY,  // Resp ready
   input  wire logic [7:0]                    S_AXI_ARADDR,  // Read addr
   input  wire logic                          S_AXI_ARVALID, // Addr valid
   output logic                               S_AXI_ARREADY, // Addr ready
   output logic      [31:0]                   S_AXI_RDATA,   // Read data
   output logic      [1:0]                    S_AXI_RRESP,   // Read resp
   output logic                               S_AXI_RVALID,  // Resp valid
   input  wire logic                          S_AXI_RREADY   // Resp ready
);

   // Configuration
   logic [rfs_pkg::CTRL_BITS-1:0]  ctrl_ff;
   logic [rfs_pkg::UID_BITS-1:0]   uid_ff;
   logic [rfs_pkg::RCNT_BITS-1:0]  mask_ff;
   logic                           stream_mode;
   logic                           drop_en;
   logic                           uid_ovr;

   // Framing state
   logic                           ev_start;
   logic                           ev_stop;
   logic                           drop_now;
   logic                           drop_ff;
   logic                           open_ff;
   logic                           ferr_ff;
   logic                           ferr_set;
   logic                           ferr_clr;
   logic                           keep_start;
   logic                           keep_stop;
   logic [rfs_pkg::GP_BITS-1:0]    last_gp_ff;
   logic [rfs_pkg::RCNT_BITS-1:0]  last_rcnt_ff;
   logic [rfs_pkg::EVT_CNT_BITS-1:0] start_cnt;
   logic [rfs_pkg::EVT_CNT_BITS-1:0] stop_cnt;
   logic [rfs_pkg::EVT_CNT_BITS-1:0] drop_cnt;
   logic                           cnt_clr;

   // Bus slave state
   logic                           aw_have_ff;
   logic                           w_have_ff;
   logic [7:0]                     awaddr_ff;
   logic [31:0]                    wdata_ff;
   logic [3:0]                     wstrb_ff;
   logic                           bvalid_ff;
   logic [1:0]                     bresp_ff;
   logic                           rvalid_ff;
   logic [1:0]                     rresp_ff;
   logic [31:0]                    rdata_ff;
   logic                           wr_go;
   logic                           wr_hit;
   logic [31:0]                    nxt_rdata;
   logic                           nxt_rhit;

   assign stream_mode = ctrl_ff[rfs_pkg::CTRL_STREAM_BIT];
   assign drop_en     = ctrl_ff[rfs_pkg::CTRL_DROP_BIT];
   assign uid_ovr     = ctrl_ff[rfs_pkg::CTRL_UIDOVR_BIT];

   // Lingering bits are ignored outside valid cycles
   assign ev_start = IN_VALID & IN_REC[rfs_pkg::REC_START_BIT];
   assign ev_stop  = IN_VALID & IN_REC[rfs_pkg::REC_STOP_BIT];

   // Drop decision taken once, at the start event; never in multi-record
   assign drop_now = ev_start & stream_mode & drop_en
                     & (|(IN_RCNT & mask_ff));

   // Start and stop of a record share one fate, so pairs stay matched
   assign keep_start = ev_start & ~drop_now;
   assign keep_stop  = ev_stop & ~(ev_start ? drop_now : drop_ff);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         open_ff <= 1'b0;
         drop_ff <= 1'b0;
      end else if (ev_start && !ev_stop) begin
         open_ff <= 1'b1;
         drop_ff <= drop_now;
      end else if (ev_stop) begin
         open_ff <= 1'b0;
         drop_ff <= 1'b0;
      end
   end

   // Upstream start while open, or stop while closed
   assign ferr_set = (ev_start & open_ff) | (ev_stop & ~ev_start & ~open_ff);
   assign ferr_clr = wr_go & wr_hit & (awaddr_ff == rfs_pkg::OFS_STATUS)
                     & wstrb_ff[0] & wdata_ff[rfs_pkg::STAT_FERR_BIT];

   // Set wins over write-one-to-clear
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ferr_ff <= 1'b0;
      end else if (ferr_set) begin
         ferr_ff <= 1'b1;
      end else if (ferr_clr) begin
         ferr_ff <= 1'b0;
      end
   end

   // Skewed vector is only trusted in the start cycle
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         last_gp_ff   <= '0;
         last_rcnt_ff <= '0;
      end else if (ev_start) begin
         last_gp_ff   <= IN_GP;
         last_rcnt_ff <= IN_RCNT;
      end
   end

   // Whole word and all sideband move on one edge; valid kept as is
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         OUT_DATA  <= '0;
         OUT_VALID <= 1'b0;
         OUT_REC   <= '0;
         OUT_OVR   <= 1'b0;
         OUT_GP    <= '0;
         OUT_RCNT  <= '0;
         OUT_UID   <= '0;
      end else begin
         OUT_DATA  <= IN_DATA;
         OUT_VALID <= IN_VALID;
         OUT_REC   <= {keep_stop, keep_start};
         OUT_OVR   <= IN_OVR;
         OUT_GP    <= IN_GP;
         OUT_RCNT  <= IN_RCNT;
         OUT_UID   <= uid_ovr ? uid_ff : IN_UID;
      end
   end

   // Members handled one by one, never as a packed bundle
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         OUT_TEVT    <= 1'b0;
         OUT_TRISE   <= 1'b0;
         OUT_TNUM    <= '0;
         OUT_REVT    <= 1'b0;
         OUT_REVT_PT <= 1'b0;
         OUT_RRISE   <= 1'b0;
         OUT_RNUM    <= '0;
         OUT_XPREC   <= '0;
      end else begin
         OUT_TEVT    <= IN_TEVT;
         OUT_TRISE   <= IN_TRISE;
         OUT_TNUM    <= IN_TNUM;
         OUT_REVT    <= IN_REVT;
         OUT_REVT_PT <= IN_REVT_PT;
         OUT_RRISE   <= IN_RRISE;
         OUT_RNUM    <= IN_RNUM;
         OUT_XPREC   <= IN_XPREC;
      end
   end

   // Statistics, cleared together by writing the control register
   assign cnt_clr = wr_go & wr_hit & (awaddr_ff == rfs_pkg::OFS_CTRL);

   rfs_evt_cnt #(.WIDTH(rfs_pkg::EVT_CNT_BITS)) u_start_cnt (
      .clk   (CLK),
      .rst_n (RESET_N),
      .inc   (keep_start),
      .clr   (cnt_clr),
      .count (start_cnt)
   );

   rfs_evt_cnt #(.WIDTH(rfs_pkg::EVT_CNT_BITS)) u_stop_cnt (
      .clk   (CLK),
      .rst_n (RESET_N),
      .inc   (keep_stop),
      .clr   (cnt_clr),
      .count (stop_cnt)
   );

   rfs_evt_cnt #(.WIDTH(rfs_pkg::EVT_CNT_BITS)) u_drop_cnt (
      .clk   (CLK),
      .rst_n (RESET_N),
      .inc   (drop_now),
      .clr   (cnt_clr),
      .count (drop_cnt)
   );

   // AXI4-Lite write: address and data latched in either order
   assign S_AXI_AWREADY = ~aw_have_ff & ~bvalid_ff;
   assign S_AXI_WREADY  = ~w_have_ff & ~bvalid_ff;
   assign wr_go  = aw_have_ff & w_have_ff & ~bvalid_ff;
   assign wr_hit = (awaddr_ff == rfs_pkg::OFS_CTRL)
                   | (awaddr_ff == rfs_pkg::OFS_UID)
                   | (awaddr_ff == rfs_pkg::OFS_DROP_MASK)
                   | (awaddr_ff == rfs_pkg::OFS_STATUS);

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         aw_have_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_ff <= 1'b1;
         awaddr_ff  <= S_AXI_AWADDR;
      end else if (wr_go) begin
         aw_have_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         w_have_ff <= 1'b0;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_ff <= 1'b1;
         wdata_ff  <= S_AXI_WDATA;
         wstrb_ff  <= S_AXI_WSTRB;
      end else if (wr_go) begin
         w_have_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= rfs_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? rfs_pkg::RESP_OKAY : rfs_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Only the low byte of each register is writable, except the drop mask, whose two low bytes are
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl_ff <= rfs_pkg::CTRL_RESET;
         uid_ff  <= rfs_pkg::UID_RESET;
         mask_ff <= rfs_pkg::MASK_RESET;
      end else if (wr_go) begin
         if (awaddr_ff == rfs_pkg::OFS_CTRL && wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[rfs_pkg::CTRL_BITS-1:0];
         end
         if (awaddr_ff == rfs_pkg::OFS_UID && wstrb_ff[0]) begin
            uid_ff <= wdata_ff[rfs_pkg::UID_BITS-1:0];
         end
         if (awaddr_ff == rfs_pkg::OFS_DROP_MASK) begin
            if (wstrb_ff[0]) mask_ff[7:0]  <= wdata_ff[7:0];
            if (wstrb_ff[1]) mask_ff[15:8] <= wdata_ff[15:8];
         end
      end
   end

   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP  = bresp_ff;

   // AXI4-Lite read
   assign S_AXI_ARREADY = ~rvalid_ff;

   always_comb begin
      nxt_rdata = '0;
      nxt_rhit  = 1'b1;
      unique case (S_AXI_ARADDR)
         rfs_pkg::OFS_CTRL:      nxt_rdata = 32'(ctrl_ff);
         rfs_pkg::OFS_UID:       nxt_rdata = 32'(uid_ff);
         rfs_pkg::OFS_DROP_MASK: nxt_rdata = 32'(mask_ff);
         rfs_pkg::OFS_STATUS: begin
            nxt_rdata[rfs_pkg::STAT_OPEN_BIT] = open_ff;
            nxt_rdata[rfs_pkg::STAT_FERR_BIT] = ferr_ff;
            nxt_rdata[rfs_pkg::STAT_DROP_BIT] = drop_ff;
         end
         rfs_pkg::OFS_START_CNT: nxt_rdata = start_cnt;
         rfs_pkg::OFS_STOP_CNT:  nxt_rdata = stop_cnt;
         rfs_pkg::OFS_DROP_CNT:  nxt_rdata = drop_cnt;
         rfs_pkg::OFS_LAST_GP:   nxt_rdata = 32'(last_gp_ff);
         rfs_pkg::OFS_LAST_RCNT: nxt_rdata = 32'(last_rcnt_ff);
         default:                nxt_rhit  = 1'b0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= rfs_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rhit ? rfs_pkg::RESP_OKAY : rfs_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA  = rdata_ff;
   assign S_AXI_RRESP  = rresp_ff;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   a_valid_with_frame: assert property (
      (|OUT_REC) |-> OUT_VALID)
      else $error("Framing bit out without data valid");
   a_invalid_bits_gone: assert property (
      !IN_VALID |=> OUT_REC == '0)
      else $error("Framing bit forwarded from invalid cycle");
   a_multi_keeps_start: assert property (
      (ev_start && !stream_mode) |=> OUT_REC[rfs_pkg::REC_START_BIT])
      else $error("Record start lost in multi-record mode");
   a_drop_pairs_stop: assert property (
      (drop_ff && ev_stop && !ev_start)
      |=> !OUT_REC[rfs_pkg::REC_STOP_BIT])
      else $error("Stop of dropped record forwarded");
   a_drop_kills_start: assert property (
      drop_now |=> !OUT_REC[rfs_pkg::REC_START_BIT])
      else $error("Start of dropped record forwarded");
   a_single_word_rec: assert property (
      (ev_start && ev_stop && !drop_now) |=> OUT_REC == 2'h3)
      else $error("Single-word record not kept whole");
   a_word_aligned: assert property (
      RESET_N |=> (OUT_DATA == $past(IN_DATA)
                   && OUT_VALID == $past(IN_VALID)))
      else $error("Data word or valid misaligned");
   a_gp_at_start: assert property (
      ev_start |=> last_gp_ff == $past(IN_GP))
      else $error("General purpose value not captured at start");
   a_uid_override: assert property (
      uid_ovr |=> OUT_UID == $past(uid_ff))
      else $error("User id override not applied");
   a_write_answer: assert property (
      wr_go |=> S_AXI_BVALID)
      else $error("Write response missing");

   c_single_word:  cover property (ev_start && ev_stop);
   c_drop_record:  cover property (drop_now ##[1:20] ev_stop);
   c_long_record:  cover property (keep_start ##[2:40] keep_stop);
   c_ferr_flag:    cover property (ferr_set);

endmodule

// ===== verif/rfs_src_model.sv
// Upstream acquisition side of one reduced rate bus channel.
// Assumes GO pulses only while BUSY is low, with LEN of one or more.
`timescale 1ns/100ps
module rfs_src_model (
   input  wire logic        CLK,           // Data clock
   input  wire logic        ARM,           // Clear record count
   input  wire logic        GO,            // Start one record
   input  wire logic [7:0]  LEN,           // Valid words in record
   input  wire logic        LING,          // Hold framing over gaps
   output logic             BUSY,          // Record under way
   output logic             VALID = 1'b0,  // Data valid
   output logic [1:0]       REC = 2'h0,    // Framing bits
   output logic [15:0]      GP = 16'h0000, // General purpose
   output logic [15:0]      RCNT = 16'h0000, // Record count
   output logic [7:0]       UID = 8'h00    // User id
);
   logic [7:0]  left = 8'h00;
   logic [15:0] cnt = 16'h0000;
   logic        first = 1'b0;
   logic        v;
   logic        s;
   assign BUSY = left != 8'h00;
   always @(posedge CLK) begin
      v = 1'($urandom);
      s = v && BUSY && first;
      VALID <= v;
      GP <= 16'($urandom);
      UID <= 8'($urandom);
      RCNT <= s ? cnt : 16'($urandom); // Garbage outside start
      if (!v)
         REC <= LING ? REC : 2'h0; // Lingers only on request
      else
         REC <= BUSY ? {left == 8'h01, first} : 2'h0;
      if (v && BUSY) begin
         left <= left - 8'h01;
         first <= 1'b0;
      end
      if (s) cnt <= cnt + 16'h0001;
      if (ARM) cnt <= 16'h0000;
      if (GO) begin
         left <= LEN;
         first <= 1'b1;
      end
   end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the second-area record framing controller.
// Assumes the upstream model drives valid, framing, GP, RCNT and UID; the bench drives the rest.
`timescale 1ns/100ps
module testbench;
   logic CLK = 1'b0, RESET_N = 1'b0, ARM = 1'b1, GO = 1'b0, LING = 1'b0;
   logic [127:0] IN_DATA = 128'h0, OUT_DATA;
   logic IN_VALID, IN_OVR = 1'b0, IN_TEVT = 1'b0, IN_TRISE = 1'b0;
   logic IN_REVT = 1'b0, IN_REVT_PT = 1'b0, IN_RRISE = 1'b0, BUSY;
   logic OUT_VALID, OUT_OVR, OUT_TEVT, OUT_TRISE, OUT_REVT, OUT_REVT_PT;
   logic OUT_RRISE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_ARREADY, S_AXI_RVALID;
   logic [1:0] IN_REC, OUT_REC, S_AXI_BRESP, S_AXI_RRESP;
   logic [7:0] IN_UID, OUT_UID, IN_TNUM = 8'h00, OUT_TNUM, OUT_RNUM;
   logic [7:0] IN_RNUM = 8'h00, LEN = 8'h01, uid = 8'h00;
   logic [15:0] IN_GP, OUT_GP, IN_RCNT, OUT_RCNT, OUT_XPREC;
   logic [15:0] IN_XPREC = 16'h0000, mask = 16'h0000;
   logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
   logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, r_d = 1'b0, drp = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [198:0] p = '0;
   logic [33:0] aq[$];
   logic [25:0] sq[$];
   int num_errors = 0, total_checks = 0;

   rfs_ul2_ctrl rfs_ul2_ctrl_i (.CLK, .RESET_N, .IN_DATA, .IN_VALID,
      .IN_REC, .IN_OVR, .IN_GP, .IN_RCNT, .IN_UID, .IN_TEVT, .IN_TRISE,
      .IN_TNUM, .IN_REVT, .IN_REVT_PT, .IN_RRISE, .IN_RNUM, .IN_XPREC,
      .OUT_DATA, .OUT_VALID, .OUT_REC, .OUT_OVR, .OUT_GP, .OUT_RCNT,
      .OUT_UID, .OUT_TEVT, .OUT_TRISE, .OUT_TNUM, .OUT_REVT, .OUT_REVT_PT,
      .OUT_RRISE, .OUT_RNUM, .OUT_XPREC, .S_AXI_AWADDR, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
   rfs_src_model rfs_src_model_i (.CLK, .ARM, .GO, .LEN, .LING, .BUSY,
      .VALID(IN_VALID), .REC(IN_REC), .GP(IN_GP), .RCNT(IN_RCNT),
      .UID(IN_UID));

   always #2.5 CLK = ~CLK;

   task automatic chk(input logic [199:0] s, input logic [199:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      @(posedge CLK);
      aq.push_back({r, 32'h0000_0000});
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      @(posedge CLK);
      aq.push_back({r, d});
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
   endtask

   task automatic rec(input logic [7:0] n);
      @(posedge CLK);
      LEN <= n;
      GO <= 1'b1;
      @(posedge CLK);
      GO <= 1'b0;
      do @(posedge CLK); while (BUSY);
   endtask

   // Driver side: random members, and notes of what must come out
   always @(posedge CLK) begin
      IN_DATA <= {$urandom, $urandom, $urandom, $urandom};
      {IN_OVR, IN_TEVT, IN_TRISE, IN_TNUM, IN_REVT, IN_REVT_PT, IN_RRISE,
       IN_RNUM, IN_XPREC} <= 38'({$urandom, $urandom});
      r_d <= RESET_N;
      p <= {IN_DATA, IN_VALID, IN_OVR, IN_TEVT, IN_TRISE, IN_TNUM, IN_REVT,
            IN_REVT_PT, IN_RRISE, IN_RNUM, IN_XPREC, IN_GP, IN_RCNT};
      if (RESET_N && IN_VALID && |IN_REC) begin
         if (IN_REC[0]) drp = mode[1:0] == 2'h3 && |(IN_RCNT & mask);
         if (!drp) sq.push_back({mode[2] ? uid : IN_UID, IN_GP, IN_REC});
      end
   end

   always @(posedge CLK) begin
      if (r_d)
         chk({OUT_DATA, OUT_VALID, OUT_OVR, OUT_TEVT, OUT_TRISE, OUT_TNUM,
              OUT_REVT, OUT_REVT_PT, OUT_RRISE, OUT_RNUM, OUT_XPREC,
              OUT_GP, OUT_RCNT}, p);
      if (|OUT_REC) begin
         chk(OUT_VALID, 1'b1);
         chk({OUT_UID, OUT_GP, OUT_REC}, sq.pop_front());
      end
      if (S_AXI_RVALID && S_AXI_RREADY)
         chk({S_AXI_RRESP, S_AXI_RDATA}, aq.pop_front());
      if (S_AXI_BVALID && S_AXI_BREADY)
         chk({S_AXI_BRESP, 32'h0000_0000}, aq.pop_front());
   end

   initial begin
      void'($urandom(29));
      repeat (8) @(posedge CLK);
      RESET_N <= 1'b1;
      ARM <= 1'b0;
      rd(rfs_pkg::OFS_CTRL, 32'h0000_0000, rfs_pkg::RESP_OKAY);
      rd(rfs_pkg::OFS_DROP_MASK, 32'h0000_0000, rfs_pkg::RESP_OKAY);
      rd(8'h40, 32'h0000_0000, rfs_pkg::RESP_SLVERR);
      rec(8'h01);
      for (int i = 0; i < 3; i++) rec(8'(1 + $urandom % 4));
      rd(rfs_pkg::OFS_START_CNT, 32'h0000_0004, rfs_pkg::RESP_OKAY);
      rd(rfs_pkg::OFS_LAST_RCNT, 32'h0000_0003, rfs_pkg::RESP_OKAY);
      wr(rfs_pkg::OFS_DROP_MASK, 32'h0000_0001, rfs_pkg::RESP_OKAY);
      wr(rfs_pkg::OFS_UID, 32'h0000_005A, rfs_pkg::RESP_OKAY);
      wr(rfs_pkg::OFS_CTRL, 32'h0000_0007, rfs_pkg::RESP_OKAY);
      mask = 16'h0001;
      uid = 8'h5A;
      mode = 3'h7;
      for (int i = 0; i < 4; i++) rec(8'h02);
      rd(rfs_pkg::OFS_DROP_CNT, 32'h0000_0002, rfs_pkg::RESP_OKAY);
      rd(rfs_pkg::OFS_STOP_CNT, 32'h0000_0002, rfs_pkg::RESP_OKAY);
      wr(rfs_pkg::OFS_DROP_CNT, 32'h0000_0000, rfs_pkg::RESP_SLVERR);
      wr(rfs_pkg::OFS_CTRL, 32'h0000_0000, rfs_pkg::RESP_OKAY);
      mode = 3'h0;
      LING <= 1'b1;
      rec(8'h01);
      rec(8'h03);
      LING <= 1'b0;
      rd(rfs_pkg::OFS_STATUS, 32'h0000_0000, rfs_pkg::RESP_OKAY);
      rd(rfs_pkg::OFS_START_CNT, 32'h0000_0002, rfs_pkg::RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk(sq.size() + aq.size(), 0);
      end_of_test;
   end

   initial begin
      #20000;
      num_errors++;
      end_of_test;
   end
endmodule
